// ===== logic/lp_entry_ctrl.sv
// Low-power entry controller: mode pins, sleep handshake, regulator and flags
//
// Design decisions made here: the APB interface to the registers and the address map.
`timescale 1ns/1ns
`default_nettype none
module lp_entry_ctrl #(
  parameter int SLEEP_REACT_CYC = lp_entry_pkg::SLEEP_REACT_CYC_DEF
) (
  input wire logic CLK_IN,
  input wire logic RST_N_IN,
  input wire logic PSEL_IN,
  input wire logic PENABLE_IN,
  input wire logic PWRITE_IN,
  input wire logic [7:0] PADDR_IN,
  input wire logic [31:0] PWDATA_IN,
  output var logic [31:0] PRDATA_OUT,
  output var logic PREADY_OUT,
  output var logic PSLVERR_OUT,
  input wire logic LOW_POWER_SELECT_N_IN,
  input wire logic ENABLE_IN,
  input wire logic BUS_RX_IN,
  input wire logic BUS_FAULT_IN,
  input wire logic WAKE_N_IN,
  output var logic RXD_OUT,
  output var logic FAULT_N_OUT,
  output var logic REGULATOR_CONTROL_OUT,
  output var logic REGULATOR_CONTROL_OE_OUT,
  output var logic IRQ_OUT
);
  import lp_entry_pkg::*;

  typedef struct packed {
    mode_t mode;
    logic [CNT_W-1:0] sleep_cnt;
    logic wake_flag;
    logic power_on_flag;
    logic reg_on;
    logic rxd;
    logic fault_n;
    logic [1:0] ctrl;
    logic [NUM_EVT-1:0] irq_status;
    logic [NUM_EVT-1:0] irq_enable;
    logic irq;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } ctrl_state_t;

  ctrl_state_t st_r;
  ctrl_state_t st_nxt;
  wake_if wk ();
  logic [1:0] pins;
  logic access;
  logic wr;
  logic [NUM_EVT-1:0] evt;
  logic [NUM_EVT-1:0] clr;
  logic timer_done;

  // Wake detector is armed in every mode but normal
  assign wk.local_en = st_r.ctrl[CTRL_LOCAL_EN_BIT];
  assign wk.bus_en = st_r.ctrl[CTRL_BUS_EN_BIT];
  assign wk.armed = (st_r.mode != MODE_NORMAL);
  assign wk.wake_n_pin = WAKE_N_IN;
  assign wk.bus_rx = BUS_RX_IN;

  wake_detect u_wake (
    .clk_in(CLK_IN),
    .rst_n_in(RST_N_IN),
    .wk(wk.det)
  );

  assign pins = {LOW_POWER_SELECT_N_IN, ENABLE_IN};
  // Second access cycle answers, so read data can come from a flop
  assign access = PSEL_IN & PENABLE_IN & ~st_r.pready;
  assign wr = PSEL_IN & PENABLE_IN & st_r.pready & PWRITE_IN;
  assign timer_done = (st_r.sleep_cnt == CNT_W'(SLEEP_REACT_CYC));

  // Next state of modes, flags, registers and outputs
  always_comb begin
    st_nxt = st_r;
    evt = '0;
    clr = '0;
    // Mode pins decode; sleep leaves only by wake or normal coding
    case (st_r.mode)
      MODE_SLEEP: begin
        if (pins == 2'h3) begin
          st_nxt.mode = MODE_NORMAL;
        end else if (st_r.wake_flag) begin
          st_nxt.mode = MODE_STANDBY;
        end
      end
      MODE_GO_SLEEP: begin
        if (pins != 2'h1) begin
          st_nxt.mode = (pins == 2'h3) ? MODE_NORMAL :
            (pins == 2'h0) ? MODE_STANDBY : MODE_POWER_ON_FLAG_STANDBY;
        end else if (timer_done && !st_r.power_on_flag && !st_r.wake_flag
            && !wk.wake_evt) begin
          st_nxt.mode = MODE_SLEEP;
        end
      end
      default: begin
        case (pins)
          2'h0: st_nxt.mode = MODE_STANDBY;
          2'h1: st_nxt.mode = MODE_GO_SLEEP;
          2'h3: st_nxt.mode = MODE_NORMAL;
          default: st_nxt.mode = MODE_POWER_ON_FLAG_STANDBY;
        endcase
      end
    endcase
    // Reaction timer runs from go-to-sleep entry and saturates
    if (st_nxt.mode == MODE_GO_SLEEP && st_r.mode == MODE_GO_SLEEP) begin
      if (!timer_done) begin
        st_nxt.sleep_cnt = st_r.sleep_cnt + CNT_W'(1);
      end
    end else begin
      st_nxt.sleep_cnt = '0;
    end
    // Refusal reported once, as the timer runs out under power-on flag
    if (st_r.mode == MODE_GO_SLEEP && st_nxt.mode == MODE_GO_SLEEP
        && st_r.sleep_cnt == CNT_W'(SLEEP_REACT_CYC - 1) && st_r.power_on_flag) begin
      evt[EVT_REFUSE_BIT] = 1'b1;
    end
    // Normal mode clears both flags; a wake sets the latch otherwise
    if (st_nxt.mode == MODE_NORMAL) begin
      st_nxt.wake_flag = 1'b0;
      st_nxt.power_on_flag = 1'b0;
    end else if (wk.wake_evt) begin
      st_nxt.wake_flag = 1'b1;
    end
    // Wake has priority over the sleep release of the regulator
    if (wk.wake_evt || st_nxt.mode != MODE_SLEEP) begin
      st_nxt.reg_on = 1'b1;
    end else if (st_r.mode == MODE_GO_SLEEP) begin
      st_nxt.reg_on = 1'b0;
    end
    evt[EVT_WAKE_BIT] = wk.wake_evt;
    evt[EVT_SLEEP_BIT] = (st_nxt.mode == MODE_SLEEP) && (st_r.mode != MODE_SLEEP);
    // Flag pins follow the next mode, so they change with the mode itself
    case (st_nxt.mode)
      MODE_NORMAL: begin
        st_nxt.rxd = BUS_RX_IN;
        st_nxt.fault_n = ~BUS_FAULT_IN;
      end
      MODE_POWER_ON_FLAG_STANDBY: begin
        st_nxt.rxd = ~st_nxt.wake_flag;
        st_nxt.fault_n = ~st_nxt.power_on_flag;
      end
      default: begin
        st_nxt.rxd = ~st_nxt.wake_flag;
        st_nxt.fault_n = ~st_nxt.wake_flag;
      end
    endcase
    // Bus slave: answer one cycle into the access phase
    st_nxt.pready = access;
    st_nxt.pslverr = 1'b0;
    st_nxt.prdata = '0;
    if (access) begin
      case (PADDR_IN)
        STATUS_OFS: st_nxt.prdata = {24'h0, st_r.reg_on, st_r.power_on_flag,
          st_r.wake_flag, 2'h0, st_r.mode};
        CTRL_OFS: st_nxt.prdata = {30'h0, st_r.ctrl};
        IRQ_STATUS_OFS: st_nxt.prdata = {29'h0, st_r.irq_status};
        IRQ_CLEAR_OFS: st_nxt.prdata = '0;
        IRQ_ENABLE_OFS: st_nxt.prdata = {29'h0, st_r.irq_enable};
        default: st_nxt.pslverr = 1'b1;
      endcase
    end
    if (wr) begin
      case (PADDR_IN)
        CTRL_OFS: st_nxt.ctrl = PWDATA_IN[1:0];
        IRQ_CLEAR_OFS: clr = PWDATA_IN[NUM_EVT-1:0];
        IRQ_ENABLE_OFS: st_nxt.irq_enable = PWDATA_IN[NUM_EVT-1:0];
        default: st_nxt.ctrl = st_r.ctrl;
      endcase
    end
    // Set wins over clear so no event is lost
    st_nxt.irq_status = (st_r.irq_status & ~clr) | evt;
    st_nxt.irq = |(st_nxt.irq_status & st_nxt.irq_enable);
  end

  // Power-on: standby, power-on flag set, regulator driven
  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      st_r <= '{mode: MODE_STANDBY, sleep_cnt: '0, wake_flag: 1'b0, power_on_flag: 1'b1,
        reg_on: 1'b1, rxd: 1'b1, fault_n: 1'b1, ctrl: CTRL_RST, irq_status: '0,
        irq_enable: IRQ_ENABLE_RST, irq: 1'b0, pready: 1'b0, pslverr: 1'b0, prdata: '0};
    end else begin
      st_r <= st_nxt;
    end
  end

  // Open drain towards supply: drive high, or float
  assign REGULATOR_CONTROL_OUT = st_r.reg_on;
  assign REGULATOR_CONTROL_OE_OUT = st_r.reg_on;
  assign RXD_OUT = st_r.rxd;
  assign FAULT_N_OUT = st_r.fault_n;
  assign IRQ_OUT = st_r.irq;
  assign PREADY_OUT = st_r.pready;
  assign PSLVERR_OUT = st_r.pslverr;
  assign PRDATA_OUT = st_r.prdata;

  default clocking cb @(posedge CLK_IN);
  endclocking
  default disable iff (!RST_N_IN);

  standby_pins_a: assert property (
    pins == 2'h0 && st_r.mode != MODE_SLEEP && st_r.mode != MODE_GO_SLEEP
    |=> st_r.mode == MODE_STANDBY
  ) else $error("standby coding not obeyed");
  normal_pins_a: assert property (
    pins == 2'h3 |=> st_r.mode == MODE_NORMAL && !st_r.power_on_flag
  ) else $error("normal coding not obeyed");
  sleep_entry_a: assert property (
    $rose(st_r.mode == MODE_SLEEP) |-> $past(st_r.sleep_cnt) == CNT_W'(SLEEP_REACT_CYC)
      && !st_r.reg_on && !REGULATOR_CONTROL_OE_OUT
  ) else $error("sleep entered early or regulator kept on");
  wake_regulator_a: assert property (
    wk.wake_evt |=> st_r.reg_on ##1 st_r.mode != MODE_SLEEP
  ) else $error("wake did not restore regulator");
  sleep_flag_pins_a: assert property (
    st_r.mode inside {MODE_GO_SLEEP, MODE_SLEEP}
    |-> RXD_OUT == !st_r.wake_flag && FAULT_N_OUT == !st_r.wake_flag
  ) else $error("wake flag not shown on flag pins");
  wake_latched_a: assert property (
    wk.wake_evt && pins != 2'h3 |=> st_r.wake_flag && !RXD_OUT
  ) else $error("wake not latched active low");
  power_on_flag_blocks_a: assert property (
    st_r.power_on_flag |=> st_r.mode != MODE_SLEEP
  ) else $error("sleep completed under power-on flag");
  timer_start_a: assert property (
    st_r.mode != MODE_GO_SLEEP ##1 st_r.mode == MODE_GO_SLEEP
    |-> st_r.sleep_cnt == '0 ##1 (st_r.mode != MODE_GO_SLEEP || st_r.sleep_cnt == CNT_W'(1))
  ) else $error("reaction timer not started");
  apb_answer_a: assert property (
    PSEL_IN && PENABLE_IN && !PREADY_OUT |=> PREADY_OUT ##1 !PREADY_OUT
  ) else $error("bus answer not one cycle late");
  // Regulator floats in sleep only; every other mode keeps supply up
  reg_float_sleep_a: assert property (
    !st_r.reg_on |-> st_r.mode == MODE_SLEEP
  ) else $error("regulator floating outside sleep");
  // Timer still running means the regulator must stay driven
  gts_reg_on_a: assert property (
    st_r.mode == MODE_GO_SLEEP |-> st_r.reg_on && REGULATOR_CONTROL_OE_OUT
  ) else $error("regulator released during go-to-sleep");
  // Standby codings never release the supply
  standby_reg_a: assert property (
    st_r.mode inside {MODE_STANDBY, MODE_POWER_ON_FLAG_STANDBY} |-> REGULATOR_CONTROL_OUT
  ) else $error("regulator dropped in standby");
  // A latched wake forbids any step into sleep
  wake_blocks_sleep_a: assert property (
    st_r.wake_flag |=> st_r.mode != MODE_SLEEP
  ) else $error("sleep entered with wake latched");
  // Latched wake is kept until the host selects normal mode
  wake_hold_a: assert property (
    st_r.wake_flag && pins != 2'h3 |=> st_r.wake_flag
  ) else $error("wake flag lost outside normal mode");
  // Refusal is only reported while the power-on flag blocks sleep
  refuse_cause_a: assert property (
    evt[EVT_REFUSE_BIT] |-> st_r.power_on_flag && st_r.mode == MODE_GO_SLEEP
  ) else $error("refusal without power-on flag");
  // Normal mode passes bus level and bus failure one cycle late
  normal_flags_a: assert property (
    pins == 2'h3 |=> RXD_OUT == $past(BUS_RX_IN) && FAULT_N_OUT == !$past(BUS_FAULT_IN)
  ) else $error("normal mode flags not passed through");
  // Sleep is reached only through an expired go-to-sleep
  sleep_from_gts_a: assert property (
    $rose(st_r.mode == MODE_SLEEP) |-> $past(st_r.mode) == MODE_GO_SLEEP
  ) else $error("sleep entered without go-to-sleep");
  // Power-on standby shows the power-on flag on the fault output
  power_on_flag_fault_a: assert property (
    st_r.mode == MODE_POWER_ON_FLAG_STANDBY |-> FAULT_N_OUT == !st_r.power_on_flag
      && RXD_OUT == !st_r.wake_flag
  ) else $error("power-on flag not shown");
  // Set beats clear, so an event in the clear cycle survives
  sticky_set_a: assert property (
    evt[EVT_WAKE_BIT] |=> st_r.irq_status[EVT_WAKE_BIT]
  ) else $error("wake event lost from status");
  // Level interrupt follows enabled status
  irq_level_a: assert property (
    (st_r.irq_status & st_r.irq_enable) != '0 |-> IRQ_OUT
  ) else $error("interrupt not raised");
  // Error and read data only in the answer cycle
  bus_err_ready_a: assert property (
    PSLVERR_OUT |-> PREADY_OUT
  ) else $error("bus error outside answer");
  bus_data_idle_a: assert property (
    !PREADY_OUT |-> PRDATA_OUT == '0
  ) else $error("read data outside answer");

  // Main scenarios reached
  sleep_reached_c: cover property ($rose(st_r.mode == MODE_SLEEP));
  power_on_flag_standby_c: cover property (st_r.mode == MODE_POWER_ON_FLAG_STANDBY);
  refused_c: cover property (evt[EVT_REFUSE_BIT]);
  wake_in_gts_c: cover property (st_r.mode == MODE_GO_SLEEP && wk.wake_evt);
  wake_in_sleep_c: cover property (st_r.mode == MODE_SLEEP ##1 st_r.mode == MODE_STANDBY);
endmodule : lp_entry_ctrl
`default_nettype wire

// ===== logic/lp_entry_pkg.sv
// Constants, types and register map of the low-power entry controller
package lp_entry_pkg;
  // Clock
  localparam int CLK_PERIOD_NS = 4;
  // Least sleep reaction time; the count rounds up
  localparam int T_SLEEP_REACT_US = 50;
  localparam int SLEEP_REACT_CYC_DEF =
    (T_SLEEP_REACT_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Least stable time on the local wake pin
  localparam int T_LOCAL_WAKE_US = 15;
  localparam int LOCAL_WAKE_CYC = (T_LOCAL_WAKE_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Least dominant time on the bus for a remote wake
  localparam int T_BUS_DOM_US = 7;
  localparam int BUS_DOM_CYC = (T_BUS_DOM_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 16;
  // Register byte offsets
  localparam logic [7:0] STATUS_OFS = 8'h00;
  localparam logic [7:0] CTRL_OFS = 8'h04;
  localparam logic [7:0] IRQ_STATUS_OFS = 8'h08;
  localparam logic [7:0] IRQ_CLEAR_OFS = 8'h0C;
  localparam logic [7:0] IRQ_ENABLE_OFS = 8'h10;
  // Reset values
  localparam logic [1:0] CTRL_RST = 2'h3;
  localparam logic [2:0] IRQ_ENABLE_RST = 3'h0;
  // Field positions
  localparam int CTRL_LOCAL_EN_BIT = 0;
  localparam int CTRL_BUS_EN_BIT = 1;
  localparam int EVT_WAKE_BIT = 0;
  localparam int EVT_SLEEP_BIT = 1;
  localparam int EVT_REFUSE_BIT = 2;
  localparam int NUM_EVT = 3;
  // Operating modes
  typedef enum logic [2:0] {
    MODE_STANDBY,
    MODE_NORMAL,
    MODE_GO_SLEEP,
    MODE_SLEEP,
    MODE_POWER_ON_FLAG_STANDBY
  } mode_t;
endpackage : lp_entry_pkg

// ===== logic/wake_detect.sv
// Filtered local and remote wake-up detector
`timescale 1ns/1ns
`default_nettype none
module wake_detect (
  input wire logic clk_in,
  input wire logic rst_n_in,
  wake_if.det wk
);
  import lp_entry_pkg::*;

  typedef struct packed {
    logic ref_level;
    logic [CNT_W-1:0] local_cnt;
    logic [CNT_W-1:0] dom_cnt;
    logic wake;
  } det_state_t;

  det_state_t st_r;
  det_state_t st_nxt;

  // Edge on the wake pin must hold; bus must stay dominant long enough
  always_comb begin
    st_nxt = st_r;
    st_nxt.wake = 1'b0;
    if (wk.wake_n_pin == st_r.ref_level) begin
      st_nxt.local_cnt = '0;
    end else if (st_r.local_cnt == CNT_W'(LOCAL_WAKE_CYC - 1)) begin
      st_nxt.local_cnt = '0;
      st_nxt.ref_level = wk.wake_n_pin;
      st_nxt.wake = wk.armed & wk.local_en;
    end else begin
      st_nxt.local_cnt = st_r.local_cnt + CNT_W'(1);
    end
    // Dominant is low; one event per dominant phase, spikes filtered
    if (wk.bus_rx) begin
      st_nxt.dom_cnt = '0;
    end else if (st_r.dom_cnt != CNT_W'(BUS_DOM_CYC)) begin
      st_nxt.dom_cnt = st_r.dom_cnt + CNT_W'(1);
      if (st_r.dom_cnt == CNT_W'(BUS_DOM_CYC - 1)) begin
        st_nxt.wake = st_nxt.wake | (wk.armed & wk.bus_en);
      end
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st_r <= '{ref_level: 1'b1, local_cnt: '0, dom_cnt: '0, wake: 1'b0};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign wk.wake_evt = st_r.wake;

  // Bus wake only after the full dominant time
  bus_wake_time_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    st_r.wake && !$past(st_r.wake) && $past(st_r.dom_cnt) == CNT_W'(BUS_DOM_CYC - 1)
    |-> $past(!wk.bus_rx) || $past(st_r.local_cnt) == CNT_W'(LOCAL_WAKE_CYC - 1)
  ) else $error("wake event without filtered cause");
  // No wake reported while disarmed
  wake_armed_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    st_r.wake |-> $past(wk.armed)
  ) else $error("wake event while not armed");
endmodule : wake_detect
`default_nettype wire

// ===== logic/wake_if.sv
// Carrier between the controller and its wake-up detector
`timescale 1ns/1ns
`default_nettype none
interface wake_if;
  logic local_en;
  logic bus_en;
  logic armed;
  logic wake_n_pin;
  logic bus_rx;
  logic wake_evt;
  modport ctrl (output local_en, output bus_en, output armed, output wake_n_pin,
    output bus_rx, input wake_evt);
  modport det (input local_en, input bus_en, input armed, input wake_n_pin,
    input bus_rx, output wake_evt);
endinterface : wake_if
`default_nettype wire

// ===== tb/host_model.sv
// Host model: drives the mode pins and watches the flag pins
`timescale 1ns/1ns
`default_nettype none
module host_model (
  input wire logic clk_in,
  input wire logic rxd_in,
  input wire logic fault_n_in,
  output var logic sel_n_out,
  output var logic en_out,
  output var logic wake_seen_out
);
  initial begin
    sel_n_out = 1'b0;
    en_out = 1'b0;
    wake_seen_out = 1'b0;
  end
  // Bus sending already stopped; a quiet wait keeps late frames from waking us
  task automatic set_mode(input logic sel_n, input logic en, input int quiet);
    repeat (quiet) @(posedge clk_in);
    @(posedge clk_in);
    sel_n_out <= sel_n;
    en_out <= en;
  endtask : set_mode
  // A low flag during go-to-sleep means supply stays up; it stays noted until normal coding
  always @(posedge clk_in) begin
    if (!sel_n_out && en_out && (!rxd_in || !fault_n_in)) begin
      wake_seen_out <= 1'b1;
    end else if (sel_n_out && en_out) begin
      wake_seen_out <= 1'b0;
    end
  end
endmodule : host_model
`default_nettype wire

// ===== tb/lp_entry_ctrl_tb.sv
// Self-checking bench for the low-power entry controller
`timescale 1ns/1ns
`default_nettype none
`define CHK(got, exp) begin compares++; if ((got) !== (exp)) begin n_errors++; \
  $display("unexpected at %0t: got %h expected %h", $time, got, exp); end end
module lp_entry_ctrl_tb;
  import lp_entry_pkg::*;
  // Longer than the bus wake time, so a wake can cut go-to-sleep short
  localparam int SRC = 2000;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic sel_n;
  logic en;
  logic bus_rx = 1'b1;
  logic bus_fault = 1'b0;
  logic wake_n = 1'b1;
  logic rxd;
  logic fault_n;
  logic reg_out;
  logic reg_oe;
  logic irq;
  logic wake_seen;
  logic [31:0] rd;
  logic err;
  int n_errors = 0;
  int compares = 0;
  int drops;
  always #(CLK_PERIOD_NS / 2) clk = ~clk;
  lp_entry_ctrl #(.SLEEP_REACT_CYC(SRC)) lp_entry_ctrl_inst (
    .CLK_IN(clk), .RST_N_IN(rst_n), .PSEL_IN(psel), .PENABLE_IN(penable),
    .PWRITE_IN(pwrite), .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata),
    .PREADY_OUT(pready), .PSLVERR_OUT(pslverr), .LOW_POWER_SELECT_N_IN(sel_n),
    .ENABLE_IN(en), .BUS_RX_IN(bus_rx), .BUS_FAULT_IN(bus_fault), .WAKE_N_IN(wake_n),
    .RXD_OUT(rxd), .FAULT_N_OUT(fault_n), .REGULATOR_CONTROL_OUT(reg_out),
    .REGULATOR_CONTROL_OE_OUT(reg_oe), .IRQ_OUT(irq));
  host_model host_model_inst (.clk_in(clk), .rxd_in(rxd), .fault_n_in(fault_n),
    .sel_n_out(sel_n), .en_out(en), .wake_seen_out(wake_seen));
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : final_report
  // One APB transfer; pready and read data taken at the rising edge itself
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge clk);
      if (pready === 1'b1) break;
    end
    if (i == 20) begin
      n_errors++;
      final_report();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    `CHK(rd, exp)
    `CHK(err, 1'b0)
  endtask : rd_chk
  // Bounded wait for the regulator output to reach a level
  task automatic wait_reg(input logic v, input int n);
    int i;
    for (i = 0; i < n; i++) begin
      @(negedge clk);
      if (reg_out === v) break;
    end
    if (i == n) begin
      n_errors++;
      final_report();
    end
  endtask : wait_reg
  // Main sequence
  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    @(negedge clk);
    `CHK({rxd, fault_n, reg_out, reg_oe, irq}, 5'h1E)
    rd_chk(STATUS_OFS, 32'h0000_00C0);
    rd_chk(CTRL_OFS, {30'h0, CTRL_RST});
    rd_chk(IRQ_ENABLE_OFS, {29'h0, IRQ_ENABLE_RST});
    apb(1'b1, 8'h14, 32'h0);
    `CHK(err, 1'b1)
    apb(1'b1, STATUS_OFS, 32'hFFFF_FFFF);
    rd_chk(STATUS_OFS, 32'h0000_00C0);
    // Bus wake disabled: a long dominant phase must not wake
    apb(1'b1, CTRL_OFS, 32'h1);
    rd_chk(CTRL_OFS, 32'h1);
    bus_rx <= 1'b0;
    repeat (BUS_DOM_CYC + 10) @(negedge clk);
    `CHK({rxd, fault_n}, 2'h3)
    @(posedge clk);
    bus_rx <= 1'b1;
    apb(1'b1, CTRL_OFS, {30'h0, CTRL_RST});
    $display("test registers done");
    // Go-to-sleep before any normal mode must not float the regulator
    host_model_inst.set_mode(1'b0, 1'b1, 0);
    repeat (SRC + 10) @(negedge clk);
    `CHK({reg_out, rxd, fault_n}, 3'h7)
    rd_chk(IRQ_STATUS_OFS, 32'h4);
    `CHK(irq, 1'b0)
    apb(1'b1, IRQ_ENABLE_OFS, 32'h6);
    repeat (2) @(negedge clk);
    `CHK(irq, 1'b1)
    apb(1'b1, IRQ_CLEAR_OFS, 32'h4);
    repeat (2) @(negedge clk);
    `CHK(irq, 1'b0)
    // Power-on standby shows the still-set power-on flag low
    host_model_inst.set_mode(1'b1, 1'b0, 0);
    repeat (2) @(negedge clk);
    `CHK({rxd, fault_n, reg_out}, 3'h5)
    rd_chk(STATUS_OFS, 32'h0000_00C4);
    $display("test refused sleep done");
    host_model_inst.set_mode(1'b1, 1'b1, 0);
    bus_fault <= 1'b1;
    repeat (2) @(negedge clk);
    `CHK({rxd, fault_n, reg_out}, 3'h5)
    rd_chk(STATUS_OFS, 32'h0000_0081);
    bus_fault <= 1'b0;
    host_model_inst.set_mode(1'b0, 1'b0, 50);
    rd_chk(STATUS_OFS, 32'h0000_0080);
    $display("test normal and standby done");
    // Sleep entry counted in edges from the go-to-sleep coding
    host_model_inst.set_mode(1'b1, 1'b1, 0);
    host_model_inst.set_mode(1'b0, 1'b1, 0);
    repeat (SRC + 1) @(posedge clk);
    @(negedge clk);
    `CHK({reg_out, reg_oe}, 2'h3)
    @(negedge clk);
    `CHK({reg_out, reg_oe}, 2'h0)
    host_model_inst.set_mode(1'b0, 1'b0, 0);
    repeat (3) @(negedge clk);
    `CHK({reg_out, irq}, 2'h1)
    rd_chk(IRQ_STATUS_OFS, 32'h2);
    apb(1'b1, IRQ_CLEAR_OFS, 32'h2);
    $display("test sleep done");
    // Local wake from sleep; a short dip is filtered
    wake_n <= 1'b0;
    repeat (20) @(posedge clk);
    wake_n <= 1'b1;
    repeat (20) @(posedge clk);
    wake_n <= 1'b0;
    repeat (LOCAL_WAKE_CYC - 50) @(negedge clk);
    `CHK(reg_out, 1'b0)
    wait_reg(1'b1, 100);
    `CHK({rxd, fault_n, reg_oe}, 3'h1)
    rd_chk(STATUS_OFS, 32'h0000_00A0);
    $display("test local wake done");
    // Bus wake in the middle of go-to-sleep keeps the regulator up
    host_model_inst.set_mode(1'b1, 1'b1, 0);
    repeat (2) @(negedge clk);
    `CHK({rxd, fault_n}, 2'h3)
    host_model_inst.set_mode(1'b0, 1'b1, 0);
    bus_rx <= 1'b0;
    drops = 0;
    repeat (SRC + 20) begin
      @(negedge clk);
      if (reg_out !== 1'b1) drops++;
    end
    `CHK(drops, 0)
    `CHK({rxd, fault_n, wake_seen}, 3'h1)
    @(posedge clk);
    bus_rx <= 1'b1;
    rd_chk(STATUS_OFS, 32'h0000_00A2);
    $display("test bus wake done");
    final_report();
  end
endmodule : lp_entry_ctrl_tb
`default_nettype wire
